// ===== logic/chp_host.sv
// host controller for the removable flash card port
// assumes card pins pass through pads resolved outside; inputs synchronous to i_clk
`timescale 1ns/1ps
module chp_host
#(
  parameter int WIDE_BUS = 1,
  parameter logic IO_ALERT = 1'b1
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // user request
  input wire logic i_req,
  input wire chp_pkg::chp_req_t i_cmd,
  input wire logic i_want_ide,
  input wire logic i_want_io,
  input wire logic i_master,
  output logic o_busy,
  output logic o_done,
  output logic [15:0] o_rdata,
  output chp_pkg::chp_mode_t o_mode,
  output logic o_seated,
  output logic o_alert,
  output logic o_batt_ok,
  // card pins driven by host
  output chp_pkg::chp_strobe_t o_pins,
  output logic [10:0] o_addr,
  output logic [15:0] o_data,
  output logic o_data_lo_oe,
  output logic o_data_hi_oe,
  // card pins sensed by host
  input wire logic [15:0] i_data,
  input wire logic i_insert_detect_one_n,
  input wire logic i_insert_detect_two_n,
  input wire logic i_battery_status_one,
  input wire logic i_battery_status_two,
  input wire logic i_status_changed_n,
  // two-way handshake lines, then the one-way role select output
  input wire logic i_pass_diagnostic_n,
  output logic o_pass_diagnostic_n,
  output logic o_pass_diagnostic_oe,
  input wire logic i_drive_active_slave_present_n,
  output logic o_drive_active_slave_present_n,
  output logic o_drive_active_slave_present_oe,
  output logic o_drive_role_select_n
);
  typedef enum logic [2:0] {CHP_OFF, CHP_POWER, CHP_CONFIG, CHP_IDLE, CHP_STROBE, CHP_END} chp_state_t;

  // refuse bus widths the lane planner cannot serve
  if (WIDE_BUS > 1 || WIDE_BUS < 0)
  begin : g_bad_width
    $error("WIDE_BUS must be 0 or 1");
  end

  chp_state_t state_r;
  logic [7:0] cnt_r;
  logic [3:0] seat_r;
  logic cfg_io_r;
  chp_pkg::chp_req_t cmd_r;
  logic ce_lo_nxt, ce_hi_nxt, swap_nxt;
  logic swap_r;

  chp_lane u_lane
  (
    .i_mode(o_mode),
    .i_word(i_cmd.word),
    .i_a0(i_cmd.addr[0]),
    .i_wide_bus(WIDE_BUS == 1),
    .o_ce_low_n(ce_lo_nxt),
    .o_ce_high_n(ce_hi_nxt),
    .o_swap(swap_nxt)
  );

  // output-enable low through power-up picks ide; the choice then holds
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state_r <= CHP_POWER;
      cnt_r <= 8'h00;
      o_mode <= chp_pkg::CHP_MEM;
      cfg_io_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        CHP_POWER:
        begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'(chp_pkg::PWRUP_CYC - 1))
          begin
            o_mode <= i_want_ide ? chp_pkg::CHP_IDE : chp_pkg::CHP_MEM;
            cfg_io_r <= i_want_io && !i_want_ide;
            state_r <= (i_want_io && !i_want_ide) ? CHP_CONFIG : CHP_IDLE;
            cnt_r <= 8'h00;
          end
        end
        CHP_CONFIG:
        begin
          // one attribute write of the option register at the config base
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'(chp_pkg::STROBE_CYC))
          begin
            o_mode <= chp_pkg::CHP_IO;
            state_r <= CHP_IDLE;
            cnt_r <= 8'h00;
          end
        end
        CHP_IDLE:
        begin
          if (i_req && o_seated)
          begin
            state_r <= CHP_STROBE;
            cnt_r <= 8'h00;
          end
        end
        CHP_STROBE:
        begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r == 8'(chp_pkg::STROBE_CYC - 1))
            state_r <= CHP_END;
        end
        CHP_END:
          state_r <= CHP_IDLE;
        default:
          state_r <= CHP_POWER;
      endcase
    end
  end

  // pin drive: ide holds output-enable low and write-enable high throughout
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_pins <= '1;
      o_addr <= 11'h000;
      o_data <= 16'h0000;
      o_data_lo_oe <= 1'b0;
      o_data_hi_oe <= 1'b0;
      cmd_r <= '0;
      swap_r <= 1'b0;
    end
    else if (state_r == CHP_POWER)
    begin
      o_pins.oe_n <= !i_want_ide;
    end
    else if (state_r == CHP_CONFIG)
    begin
      o_addr <= chp_pkg::CFG_BASE;
      o_data <= 16'h0001;
      o_data_lo_oe <= 1'b1;
      o_pins.reg_n <= 1'b0;
      o_pins.ce_low_n <= 1'b0;
      o_pins.we_n <= (cnt_r == 8'(chp_pkg::STROBE_CYC));
    end
    else if (state_r == CHP_IDLE && i_req && o_seated)
    begin
      cmd_r <= i_cmd;
      swap_r <= swap_nxt;
      if (o_mode == chp_pkg::CHP_IDE)
      begin
        o_addr <= {8'h00, i_cmd.addr[2:0]};
        o_pins.ce_low_n <= i_cmd.ctl_blk;
        o_pins.ce_high_n <= !i_cmd.ctl_blk;
        o_pins.iord_n <= i_cmd.wr;
        o_pins.iowr_n <= !i_cmd.wr;
        o_pins.we_n <= 1'b1;
        o_pins.oe_n <= 1'b0;
        o_data_hi_oe <= i_cmd.wr && i_cmd.word && (WIDE_BUS == 1);
      end
      else
      begin
        o_addr <= i_cmd.addr;
        o_pins.reg_n <= !i_cmd.attr;
        o_pins.ce_low_n <= ce_lo_nxt;
        o_pins.ce_high_n <= ce_hi_nxt;
        o_pins.oe_n <= i_cmd.wr || (o_mode == chp_pkg::CHP_IO);
        o_pins.we_n <= !i_cmd.wr || (o_mode == chp_pkg::CHP_IO);
        o_pins.iord_n <= i_cmd.wr || (o_mode != chp_pkg::CHP_IO);
        o_pins.iowr_n <= !i_cmd.wr || (o_mode != chp_pkg::CHP_IO);
        o_data_hi_oe <= i_cmd.wr && (WIDE_BUS == 1) && !ce_hi_nxt;
      end
      o_data <= swap_nxt ? {i_cmd.wdata[7:0], 8'h00} : i_cmd.wdata;
      o_data_lo_oe <= i_cmd.wr;
    end
    else if (state_r == CHP_END || state_r == CHP_IDLE)
    begin
      // release everything between cycles; ide keeps output-enable low
      o_pins <= '1;
      o_pins.oe_n <= (o_mode != chp_pkg::CHP_IDE);
      o_pins.reg_n <= 1'b1;
      o_data_lo_oe <= 1'b0;
      o_data_hi_oe <= 1'b0;
    end
  end

  // read capture at the end of the strobe, byte lanes restored
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_rdata <= 16'h0000;
      o_done <= 1'b0;
      o_busy <= 1'b1;
    end
    else
    begin
      o_done <= (state_r == CHP_END);
      o_busy <= !(state_r == CHP_IDLE && !(i_req && o_seated));
      if (state_r == CHP_STROBE && cnt_r == 8'(chp_pkg::STROBE_CYC - 1) && !cmd_r.wr)
      begin
        if (o_mode == chp_pkg::CHP_IDE && !cmd_r.word)
          o_rdata <= {8'h00, i_data[7:0]};
        else if (swap_r)
          o_rdata <= {8'h00, i_data[15:8]};
        else
          o_rdata <= (cmd_r.word && WIDE_BUS == 1) ? i_data : {8'h00, i_data[7:0]};
      end
    end
  end

  // seated only after both detects read low for a settling time
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      seat_r <= 4'h0;
      o_seated <= 1'b0;
    end
    else if (i_insert_detect_one_n || i_insert_detect_two_n)
    begin
      seat_r <= 4'h0;
      o_seated <= 1'b0;
    end
    else if (seat_r == 4'(chp_pkg::SEAT_CYC))
      o_seated <= 1'b1;
    else
      seat_r <= seat_r + 4'h1;
  end

  // status pins: meaning depends on the latched mode
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_alert <= 1'b0;
      o_batt_ok <= 1'b0;
    end
    else
    begin
      o_alert <= (o_mode == chp_pkg::CHP_IO) && IO_ALERT && !i_status_changed_n;
      o_batt_ok <= (o_mode == chp_pkg::CHP_MEM) && i_battery_status_one && i_battery_status_two;
    end
  end

  // handshake lines: host only senses them, role select set from user choice in ide mode, held high otherwise
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_pass_diagnostic_n <= 1'b1;
      o_pass_diagnostic_oe <= 1'b0;
      o_drive_active_slave_present_n <= 1'b1;
      o_drive_active_slave_present_oe <= 1'b0;
      o_drive_role_select_n <= 1'b1;
    end
    else
    begin
      o_pass_diagnostic_oe <= 1'b0;
      o_drive_active_slave_present_oe <= 1'b0;
      o_drive_role_select_n <= !(i_master && o_mode == chp_pkg::CHP_IDE);
    end
  end

  a_ide_we_high: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_mode == chp_pkg::CHP_IDE && state_r == CHP_STROBE) |-> o_pins.we_n) else $error("we low in ide");
  a_ide_addr_low: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_mode == chp_pkg::CHP_IDE && state_r == CHP_STROBE) |-> o_addr[10:3] == 8'h00) else $error("ide upper addr");
  a_mode_held: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_r == CHP_IDLE) |=> $stable(o_mode)) else $error("mode changed");
  a_no_handshake: assert property (@(posedge i_clk) disable iff (i_reset)
    !o_pass_diagnostic_oe && !o_drive_active_slave_present_oe) else $error("host drove card line");
  a_seat_both: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_insert_detect_one_n || i_insert_detect_two_n) |=> !o_seated) else $error("seated while open");
  a_high_odd: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_r == CHP_STROBE && o_mode != chp_pkg::CHP_IDE && !o_pins.ce_high_n && o_pins.ce_low_n)
    |-> swap_r) else $error("high enable not odd");
  a_cfg_base: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_r == CHP_CONFIG && cnt_r == 8'h02) |-> (o_addr == chp_pkg::CFG_BASE && !o_pins.reg_n))
    else $error("config not at base");
  a_done_pulse: assert property (@(posedge i_clk) disable iff (i_reset)
    o_done |=> !o_done) else $error("done too long");
  a_ide_select: assert property (@(posedge i_clk) disable iff (i_reset)
    (o_mode == chp_pkg::CHP_IDE && state_r == CHP_STROBE)
    |-> (o_pins.ce_low_n == cmd_r.ctl_blk && o_pins.ce_high_n == !cmd_r.ctl_blk))
    else $error("ide select wrong");
endmodule

// ===== logic/chp_lane.sv
// byte-lane planner: card enables and data lanes for one access
// assumes the caller registers the outputs
`timescale 1ns/1ps
module chp_lane
(
  // access
  input wire chp_pkg::chp_mode_t i_mode,
  input wire logic i_word,
  input wire logic i_a0,
  input wire logic i_wide_bus,
  // lanes
  output logic o_ce_low_n,
  output logic o_ce_high_n,
  output logic o_swap
);
  // word access needs both enables; narrow hosts use low enable with a0
  always_comb
  begin
    o_ce_low_n = 1'b0;
    o_ce_high_n = 1'b1;
    o_swap = 1'b0;
    if (i_mode == chp_pkg::CHP_IDE)
    begin
      o_ce_high_n = 1'b1;
    end
    else if (i_word && i_wide_bus)
    begin
      o_ce_high_n = 1'b0;
    end
    else if (i_a0 && i_wide_bus)
    begin
      o_ce_low_n = 1'b1;
      o_ce_high_n = 1'b0;
      o_swap = 1'b1;
    end
    else
    begin
      o_ce_high_n = 1'b1;
    end
  end
endmodule

// ===== logic/chp_pkg.sv
// package for the card host port controller: constants, modes and carriers
// assumes one 10 MHz clock; the card pins are reached through tri-state pads outside
//
// Overview of operation
// - host grounds upper address lines in ide
// - pass diagnostic is two-way handshake line
// - drive active line is two-way handshake
// - both insert detects grounded; host checks both
// - 8-bit host leaves upper lanes open
// - host holds write enable high in ide
// - ultra dma renames strobe and ready pins
// - each party drives only its own pins
package chp_pkg;
  localparam logic [10:0] CFG_BASE = 11'h200;
  localparam int PWRUP_NS = 1000;
  localparam int CLK_NS = 100;
  localparam int PWRUP_CYC = (PWRUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int SEAT_NS = 500;
  localparam int SEAT_CYC = (SEAT_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_NS = 300;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {CHP_MEM, CHP_IO, CHP_IDE} chp_mode_t;

  // one access request from the user side
  typedef struct packed {
    logic wr;
    logic attr;
    logic word;
    logic ctl_blk;
    logic [10:0] addr;
    logic [15:0] wdata;
  } chp_req_t;

  // card select and strobe pins as the host drives them
  typedef struct packed {
    logic ce_low_n;
    logic ce_high_n;
    logic reg_n;
    logic oe_n;
    logic we_n;
    logic iord_n;
    logic iowr_n;
  } chp_strobe_t;
endpackage

// ===== test/chp_card.sv
// card model: the flash card as seen at the host port pins
// assumes bench reset stands in for a power cycle
`timescale 1ns/1ps
module chp_card
(
  // clock and power-up
  input wire logic i_clk,
  input wire logic i_reset,
  // host pins
  input wire chp_pkg::chp_strobe_t i_pins,
  input wire logic [10:0] i_addr,
  input wire logic [15:0] i_wdata,
  // bench controls
  input wire logic i_unseat,
  input wire logic i_event,
  // card pins
  output logic [15:0] o_data,
  output logic o_cd_n,
  output logic o_bs1,
  output logic o_bs2,
  output logic o_status_changed_n_n,
  output logic o_ide,
  output logic o_io_cfg
);
  int pwr;
  logic [15:0] last;
  function automatic logic [7:0] bt(input logic [10:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction
  // mode taken once mid power-up, later oe changes ignored
  always_ff @(posedge i_clk)
  begin
    last <= i_reset ? 16'h0000 : o_data;
    if (i_reset)
    begin
      pwr <= 0;
      o_ide <= 1'b0;
      o_io_cfg <= 1'b0;
    end
    else if (pwr < chp_pkg::PWRUP_CYC)
    begin
      pwr <= pwr + 1;
      if (pwr == chp_pkg::PWRUP_CYC / 2)
        o_ide <= !i_pins.oe_n;
    end
    else if (!i_pins.we_n && !i_pins.reg_n && !i_pins.ce_low_n && i_addr == chp_pkg::CFG_BASE)
      o_io_cfg <= i_wdata[0];
  end
  // read lanes; a released bus shows a changing pattern, never the old value
  always_comb
  begin
    o_data = ~last;
    if ((!i_pins.ce_low_n || !i_pins.ce_high_n) && (!i_pins.iord_n || (!i_pins.oe_n && !o_ide)))
    begin
      if (o_ide)
        o_data[7:0] = bt({8'h00, i_addr[2:0]});
      else
      begin
        if (!i_pins.ce_high_n)
          o_data[15:8] = bt({i_addr[10:1], 1'b1});
        if (!i_pins.ce_low_n)
          o_data[7:0] = bt({i_addr[10:1], i_pins.ce_high_n & i_addr[0]});
      end
    end
  end
  // status pins; detect follows unseat, bs1 and status change follow the event once io is configured, bs2 fixed high
  assign o_cd_n = i_unseat;
  assign o_bs1 = !(o_io_cfg && i_event);
  assign o_bs2 = 1'b1;
  assign o_status_changed_n_n = !(o_io_cfg && i_event);
endmodule

// ===== test/chp_host_tb_top.sv
// bench top for the card host port controller
// assumes the card model answers every access; handshake lines pulled high
`timescale 1ns/1ps
`define CHK(n,e,g) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("mismatch %s exp %h got %h", n, e, g); end end
module chp_host_tb_top;
  logic clk = 0, rst = 1, req = 0, w_ide = 0, w_io = 0, mst = 0, unseat = 0, evt = 0, half = 0;
  logic busy, done, seated, alert, batt, lo_oe, hi_oe, pd_oe, da_oe, role, cd_n, bs1, bs2, sc_n, ide, iocfg;
  logic [15:0] rd, od, id, ds;
  logic [10:0] ad, as;
  chp_pkg::chp_mode_t mode;
  chp_pkg::chp_strobe_t pins, ps;
  chp_pkg::chp_req_t cmd = '0;
  logic hs, lo;
  int n_fail = 0, check_count = 0, cyc = 0;
  chp_host dut (.i_clk(clk), .i_reset(rst), .i_req(req), .i_cmd(cmd), .i_want_ide(w_ide), .i_want_io(w_io),
    .i_master(mst), .o_busy(busy), .o_done(done), .o_rdata(rd), .o_mode(mode), .o_seated(seated),
    .o_alert(alert), .o_batt_ok(batt), .o_pins(pins), .o_addr(ad), .o_data(od), .o_data_lo_oe(lo_oe),
    .o_data_hi_oe(hi_oe), .i_data(id), .i_insert_detect_one_n(cd_n), .i_insert_detect_two_n(cd_n | half),
    .i_battery_status_one(bs1), .i_battery_status_two(bs2), .i_status_changed_n(sc_n),
    .i_pass_diagnostic_n(1'b1), .o_pass_diagnostic_n(), .o_pass_diagnostic_oe(pd_oe),
    .i_drive_active_slave_present_n(1'b1), .o_drive_active_slave_present_n(),
    .o_drive_active_slave_present_oe(da_oe), .o_drive_role_select_n(role));
  chp_card card (.i_clk(clk), .i_reset(rst), .i_pins(pins), .i_addr(ad), .i_wdata(od), .i_unseat(unseat),
    .i_event(evt), .o_data(id), .o_cd_n(cd_n), .o_bs1(bs1), .o_bs2(bs2), .o_status_changed_n_n(sc_n), .o_ide(ide),
    .o_io_cfg(iocfg));
  function automatic logic [7:0] bt(input logic [10:0] a);
    return a[7:0] ^ 8'hA5;
  endfunction
  // free running clock
  initial
    forever #50 clk = ~clk;
  // hang guard, far above the few hundred cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      end_of_test;
    end
  end
  // host never drives the handshake lines
  always @(negedge clk)
    if (!rst)
      `CHK("hs_oe", 2'b00, {pd_oe, da_oe})
  task end_of_test;
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task wait_idle;
    int k;
    k = 0;
    while ((busy !== 1'b0 || seated !== 1'b1) && k < 100)
    begin
      @(negedge clk);
      k++;
    end
  endtask
  task power(input logic i, input logic o, input logic m);
    @(negedge clk);
    rst = 1;
    w_ide = i;
    w_io = o;
    mst = m;
    repeat (12) @(negedge clk);
    rst = 0;
    wait_idle;
  endtask
  // one access; pins sampled mid strobe
  task acc(input chp_pkg::chp_req_t c);
    int k;
    wait_idle;
    req = 1;
    cmd = c;
    @(negedge clk);
    req = 0;
    @(negedge clk);
    ps = pins;
    as = ad;
    ds = od;
    hs = hi_oe;
    lo = lo_oe;
    k = 0;
    while (done !== 1'b1 && k < 20)
    begin
      @(negedge clk);
      k++;
    end
    `CHK("done", 1'b1, done)
  endtask
  task t_mem;
    power(0, 0, 0);
    `CHK("mode", chp_pkg::CHP_MEM, mode)
    `CHK("batt", 1'b1, batt)
    acc('{0, 0, 1, 0, 11'h010, 16'h0});
    `CHK("word", {bt(11'h011), bt(11'h010)}, rd)
    `CHK("ce_w", 2'b00, {ps.ce_low_n, ps.ce_high_n})
    `CHK("lo_rd", 1'b0, lo)
    acc('{0, 0, 0, 0, 11'h012, 16'h0});
    `CHK("even", bt(11'h012), rd[7:0])
    `CHK("ce_e", 2'b01, {ps.ce_low_n, ps.ce_high_n})
    acc('{0, 0, 0, 0, 11'h013, 16'h0});
    `CHK("odd", bt(11'h013), rd[7:0])
    acc('{1, 1, 1, 0, 11'h3FE, 16'hBEEF});
    `CHK("wr", {2'b00, 11'h3FE, 16'hBEEF}, {ps.we_n, ps.reg_n, as, ds})
    `CHK("lo_wr", 1'b1, lo)
  endtask
  // unseated card refuses requests until both detects settle
  task t_seat;
    int k;
    half = 1;
    repeat (3) @(negedge clk);
    `CHK("half_seat", 1'b0, seated)
    half = 0;
    unseat = 1;
    repeat (3) @(negedge clk);
    `CHK("seat", 1'b0, seated)
    req = 1;
    k = 0;
    repeat (8)
    begin
      @(negedge clk);
      k += (done === 1'b1);
    end
    `CHK("refuse", 0, k)
    req = 0;
    unseat = 0;
    repeat (3) @(negedge clk);
    `CHK("debounce", 1'b0, seated)
    acc('{0, 0, 1, 0, 11'h020, 16'h0});
    `CHK("back", {bt(11'h021), bt(11'h020)}, rd)
  endtask
  task t_io;
    power(0, 1, 0);
    `CHK("mode", chp_pkg::CHP_IO, mode)
    `CHK("cfg", 1'b1, iocfg)
    `CHK("batt", 1'b0, batt)
    acc('{0, 0, 0, 0, 11'h00E, 16'h0});
    `CHK("io_rd", bt(11'h00E), rd[7:0])
    `CHK("iord", 2'b01, {ps.iord_n, ps.oe_n})
    evt = 1;
    repeat (3) @(negedge clk);
    `CHK("alert", 1'b1, alert)
    evt = 0;
    repeat (3) @(negedge clk);
    `CHK("alert", 1'b0, alert)
  endtask
  task t_ide;
    power(1, 0, 1);
    w_ide = 0;
    `CHK("mode", chp_pkg::CHP_IDE, mode)
    `CHK("role", 1'b0, role)
    acc('{0, 0, 0, 0, 11'h7FD, 16'h0});
    `CHK("tf", bt(11'h005), rd[7:0])
    `CHK("addr", 11'h005, as)
    `CHK("cs0", 2'b01, {ps.ce_low_n, ps.ce_high_n})
    acc('{1, 0, 0, 1, 11'h006, 16'h0042});
    `CHK("cs1", 2'b10, {ps.ce_low_n, ps.ce_high_n})
    `CHK("lanes", 1'b0, hs)
    `CHK("we", 1'b1, ps.we_n)
    `CHK("keep", chp_pkg::CHP_IDE, mode)
    power(1, 0, 0);
    `CHK("slave", 1'b1, role)
  endtask
  // main sequence
  initial
  begin
    t_mem;
    t_seat;
    t_io;
    t_ide;
    end_of_test;
  end
endmodule
